// [src/ssr_dev.sv]
`timescale 1ns/100ps
`default_nettype none
// Operation
// (R1) request: code 22h, tag, offset, count, channel
// (R2) request outstanding until its last frame
// (R3) request tag copies the command tag
// (R4) offset is a multiple of eight
// (R5) count multiple of eight unless final
// (R6) offset plus count within transfer length
// (R7) same channel: finish first transfer first
// (R8) channel allocated before request; bad fields abort
// (R9) data frames go to the requested channel
// (R10) new request only after frames for all
// (R11) one frame never spans two requests
// (R12) redirect: code 23h and its field layout
// (R13) redirect outstanding until third party done
// (R14) wrong return path raises an alert
// (R15) bad count modulo eight raises alert
// (R16) short redirect followed by another one
// (R17) frame address from path and channel
// (R18) redirect repeats the offer transfer id
// (R19) same channel redirects run one after another; the device compares only with the channel of the last redirect issued
// (R20) other bad fields get a response
// (R21) redirect tag copied from the offer
// (R22) multi-byte fields travel msb first
module ssr_dev (
  input wire logic REF_CLK,
  input wire logic RESETN,
  ssr_link_if.dev LNK,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [31:0] REQ_OFFSET,
  input wire logic [31:0] REQ_COUNT,
  input wire logic [15:0] REQ_CHAN,
  input wire logic REQ_FINAL,
  input wire logic [31:0] IO_LEN,
  output logic REQ_REJECT,
  output logic [1:0] REQ_PENDING,
  output logic RX_VALID,
  output logic [7:0] RX_DATA,
  output logic [15:0] RX_CHAN,
  input wire logic [15:0] CMD_TAG,
  input wire logic [31:0] CMD_RPID,
  input wire logic [31:0] REM_LEN,
  output logic RDR_VALID,
  output logic [47:0] RDR_ADDR,
  output logic [7:0] RDR_PORT,
  output logic [31:0] RDR_COUNT,
  output logic [15:0] RDR_XID,
  input wire logic RDR_DONE,
  output logic ALERT_VALID,
  output logic [7:0] ALERT_CODE,
  output logic RESP_VALID,
  output logic [7:0] RESP_CODE
);
  logic [1:0] slot_busy, slot_got, slot_hit, chan_clash;
  logic [15:0] slot_chan [2];
  logic [31:0] slot_rem [2];
  logic tx_busy_reg;
  logic [4:0] tx_pos_reg, rx_pos_reg;
  logic [111:0] tx_sh_reg;
  logic [159:0] rx_sh_reg;
  logic [15:0] rx_chan_reg;
  logic go_pend_reg;
  logic [167:0] rdr_msg_reg;
  logic [1:0] rdr_cnt_reg;
  logic [15:0] last_chan_reg;

  // request admission checks
  wire [32:0] req_end = {1'b0, REQ_OFFSET} + {1'b0, REQ_COUNT};
  wire req_ok = !(|REQ_OFFSET[2:0]) // see (R4)
    && (!(|REQ_COUNT[2:0]) || REQ_FINAL) // see (R5)
    && req_end <= {1'b0, IO_LEN} && (|REQ_COUNT); // see (R6)
  // every open request must have seen a frame before the next one
  wire gate_ok = (slot_busy & ~slot_got) == 2'h0; // see (R10)
  // a channel still in use is held back so transfers never mix
  assign REQ_READY = !tx_busy_reg && !(&slot_busy) && gate_ok
    && !(|chan_clash); // see (R7)
  wire req_fire = REQ_VALID && REQ_READY;
  wire req_load = req_fire && req_ok;
  wire alloc_idx = slot_busy[0];
  assign REQ_PENDING = slot_busy;

  // incoming stream; stalled while a redirect waits for its channel
  wire rx_fire = LNK.o2d_valid && LNK.o2d_ready;
  assign LNK.o2d_ready = !go_pend_reg;
  wire rx_pay = rx_fire && LNK.o2d_frame
    && rx_pos_reg >= ssr_pkg::FRAME_HDR;
  wire sms_end = rx_fire && !LNK.o2d_frame && LNK.o2d_last;

  // request slots: channel, bytes still due, frame seen
  for (genvar i = 0; i < 2; i++) begin : g_slot
    assign slot_hit[i] = slot_busy[i] && rx_pay
      && slot_chan[i] == rx_chan_reg;
    assign chan_clash[i] = slot_busy[i] && slot_chan[i] == REQ_CHAN;
    always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
        slot_busy[i] <= 1'b0;
        slot_got[i] <= 1'b0;
        slot_chan[i] <= 16'h0000;
        slot_rem[i] <= 32'h0;
      end else if (req_load && alloc_idx == 1'(i)) begin
        slot_busy[i] <= 1'b1; // see (R8)
        slot_got[i] <= 1'b0;
        slot_chan[i] <= REQ_CHAN;
        slot_rem[i] <= REQ_COUNT;
      end else if (slot_hit[i]) begin
        slot_got[i] <= 1'b1;
        slot_rem[i] <= slot_rem[i] - 32'h1;
        if (slot_rem[i] == 32'h1) slot_busy[i] <= 1'b0; // see (R2)
      end
    end
  end

  // request serializer, byte 0 first
  assign LNK.d2o_valid = tx_busy_reg;
  assign LNK.d2o_data = tx_sh_reg[111:104];
  assign LNK.d2o_last = tx_pos_reg == ssr_pkg::REQ_LAST_POS;
  assign LNK.d2o_frame = 1'b0;
  wire tx_fire = LNK.d2o_valid && LNK.d2o_ready;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_busy_reg <= 1'b0;
      tx_pos_reg <= 5'h00;
      tx_sh_reg <= '0;
    end else if (req_load) begin
      tx_busy_reg <= 1'b1;
      tx_pos_reg <= 5'h00;
      tx_sh_reg <= {ssr_pkg::CODE_DATA_REQ, ssr_pkg::RSVD_BYTE,
        CMD_TAG, REQ_OFFSET, REQ_COUNT,
        REQ_CHAN}; // see (R1) (R3) (R22)
    end else if (tx_fire) begin
      tx_sh_reg <= {tx_sh_reg[103:0], ssr_pkg::RSVD_BYTE};
      tx_pos_reg <= tx_pos_reg + 5'h1;
      if (LNK.d2o_last) tx_busy_reg <= 1'b0;
    end
  end

  // receive framing: byte position, message bytes, frame channel
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_pos_reg <= 5'h00;
      rx_sh_reg <= '0;
      rx_chan_reg <= 16'h0000;
    end else if (rx_fire) begin
      rx_sh_reg <= {rx_sh_reg[151:0], LNK.o2d_data};
      rx_pos_reg <= LNK.o2d_last ? 5'h00 :
        (rx_pos_reg == ssr_pkg::POS_MAX ? rx_pos_reg : rx_pos_reg + 5'h1);
      if (LNK.o2d_frame && rx_pos_reg < ssr_pkg::FRAME_HDR) begin
        rx_chan_reg <= {rx_chan_reg[7:0], LNK.o2d_data};
      end
    end
  end

  // redirect check at its last byte, in order of precedence
  wire [167:0] msg = {rx_sh_reg, LNK.o2d_data};
  wire [31:0] m_cnt = msg[ssr_pkg::RD_CNT +: 32];
  wire is_rdr = msg[ssr_pkg::RD_CODE +: 8] == ssr_pkg::CODE_REDIRECT
    && rx_pos_reg == ssr_pkg::RDR_LAST_POS; // see (R12)
  wire bad_rpid = msg[ssr_pkg::RD_RPID +: 32] != CMD_RPID;
  wire bad_mod8 = (|m_cnt[2:0]) && m_cnt != REM_LEN;
  wire bad_other = !(|m_cnt) || m_cnt > REM_LEN
    || msg[ssr_pkg::RD_TAG +: 16] != CMD_TAG;
  wire too_many = rdr_cnt_reg == ssr_pkg::MAX_RDR;
  wire pass_alert = is_rdr && !bad_rpid && !bad_mod8;
  wire alert_now = sms_end && (!pass_alert || (!bad_other && too_many));
  wire [7:0] alert_sel = !is_rdr ? ssr_pkg::ALERT_UNEXPECTED :
    bad_rpid ? ssr_pkg::ALERT_BAD_RPATH : // see (R14)
    bad_mod8 ? ssr_pkg::ALERT_BAD_FIELD : // see (R15)
    ssr_pkg::ALERT_TOO_MANY;
  wire resp_now = sms_end && pass_alert && bad_other; // see (R20)
  wire rdr_take = sms_end && pass_alert && !bad_other && !too_many;

  // a held redirect starts once none is outstanding or its channel differs from the last one issued
  wire [15:0] held_chan = rdr_msg_reg[ssr_pkg::RD_CHAN +: 16];
  wire go_issue = go_pend_reg && (rdr_cnt_reg == 2'h0
    || held_chan != last_chan_reg); // see (R19)
  wire done_ok = RDR_DONE && rdr_cnt_reg != 2'h0;
  assign RDR_ADDR = {rdr_msg_reg[ssr_pkg::RD_OPATH +: 32],
    held_chan}; // see (R17)
  assign RDR_PORT = rdr_msg_reg[ssr_pkg::RD_OPORT +: 8];
  assign RDR_COUNT = rdr_msg_reg[ssr_pkg::RD_CNT +: 32];
  assign RDR_XID = rdr_msg_reg[ssr_pkg::RD_XID +: 16];

  // redirect hold and outstanding count
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      go_pend_reg <= 1'b0;
      rdr_msg_reg <= '0;
      rdr_cnt_reg <= 2'h0;
      last_chan_reg <= 16'h0000;
      RDR_VALID <= 1'b0;
    end else begin
      RDR_VALID <= go_issue;
      // counts down only on the third party's completion
      rdr_cnt_reg <= rdr_cnt_reg + {1'b0, go_issue}
        - {1'b0, done_ok}; // see (R13)
      if (rdr_take) begin
        go_pend_reg <= 1'b1;
        rdr_msg_reg <= msg;
      end else if (go_issue) begin
        go_pend_reg <= 1'b0;
        last_chan_reg <= held_chan;
      end
    end
  end

  // user-facing pulses; rejections never end the process
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      REQ_REJECT <= 1'b0;
      RX_VALID <= 1'b0;
      RX_DATA <= 8'h00;
      RX_CHAN <= 16'h0000;
      ALERT_VALID <= 1'b0;
      ALERT_CODE <= 8'h00;
      RESP_VALID <= 1'b0;
      RESP_CODE <= 8'h00;
    end else begin
      REQ_REJECT <= req_fire && !req_ok;
      RX_VALID <= |slot_hit;
      if (rx_pay) begin
        RX_DATA <= LNK.o2d_data;
        RX_CHAN <= rx_chan_reg;
      end
      ALERT_VALID <= alert_now;
      if (alert_now) ALERT_CODE <= alert_sel;
      RESP_VALID <= resp_now;
      if (resp_now) RESP_CODE <= ssr_pkg::RESP_BAD_FIELD;
    end
  end
endmodule
`default_nettype wire

// [src/ssr_pkg.sv]
package ssr_pkg;
  // message codes and the reserved byte
  localparam logic [7:0] CODE_DATA_REQ = 8'h22;
  localparam logic [7:0] CODE_REDIRECT = 8'h23;
  localparam logic [7:0] RSVD_BYTE = 8'h00;
  // last byte index of each message, counted from byte 0
  localparam logic [4:0] REQ_LAST_POS = 5'h0d;
  localparam logic [4:0] RDR_LAST_POS = 5'h14;
  localparam logic [4:0] POS_MAX = 5'h1f;
  // data frame layout: two channel bytes, then payload
  localparam logic [4:0] FRAME_HDR = 5'h02;
  localparam logic [7:0] FRAME_PAYLOAD = 8'h10;
  // redirect descriptors the device may hold outstanding
  localparam logic [1:0] MAX_RDR = 2'h2;
  // alert and response codes, values arbitrary
  localparam logic [7:0] ALERT_BAD_RPATH = 8'h01;
  localparam logic [7:0] ALERT_BAD_FIELD = 8'h02;
  localparam logic [7:0] ALERT_UNEXPECTED = 8'h03;
  localparam logic [7:0] ALERT_TOO_MANY = 8'h04;
  localparam logic [7:0] RESP_BAD_FIELD = 8'h05;
  // request message as 112 bits, byte 0 on top, msb first
  localparam int RQ_CODE = 104;
  localparam int RQ_TAG = 80;
  localparam int RQ_OFS = 48;
  localparam int RQ_CNT = 16;
  localparam int RQ_CHAN = 0;
  // redirect message as 168 bits, byte 0 on top, msb first
  localparam int RD_CODE = 160;
  localparam int RD_TAG = 136;
  localparam int RD_RPID = 104;
  localparam int RD_CNT = 72;
  localparam int RD_CHAN = 56;
  localparam int RD_XID = 40;
  localparam int RD_OPATH = 8;
  localparam int RD_OPORT = 0;
endpackage

// [src/ssr_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
// byte streams both ways; frame=1 marks a data frame, 0 a message
interface ssr_link_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic d2o_valid;
  logic d2o_ready;
  logic [7:0] d2o_data;
  logic d2o_last;
  logic d2o_frame;
  logic o2d_valid;
  logic o2d_ready;
  logic [7:0] o2d_data;
  logic o2d_last;
  logic o2d_frame;
  modport dev (
    output d2o_valid, d2o_data, d2o_last, d2o_frame, o2d_ready,
    input d2o_ready, o2d_valid, o2d_data, o2d_last, o2d_frame
  );
  modport peer (
    input d2o_valid, d2o_data, d2o_last, d2o_frame, o2d_ready,
    output d2o_ready, o2d_valid, o2d_data, o2d_last, o2d_frame
  );
endinterface
`default_nettype wire

// [src/ssr_peer.sv]
`timescale 1ns/100ps
`default_nettype none
// far end: serves data requests with frames, issues redirects
module ssr_peer (
  input wire logic REF_CLK,
  input wire logic RESETN,
  ssr_link_if.peer LNK,
  input wire logic [31:0] IO_LEN,
  output logic ABORT,
  output logic REQ_SEEN,
  output logic [15:0] REQ_TAG,
  output logic [31:0] REQ_OFFSET,
  output logic [31:0] REQ_COUNT,
  output logic [15:0] REQ_CHAN,
  input wire logic SRC_VALID,
  output logic SRC_READY,
  input wire logic [7:0] SRC_DATA,
  input wire logic RDR_VALID,
  output logic RDR_READY,
  input wire logic [15:0] RDR_TAG,
  input wire logic [31:0] RDR_RPID,
  input wire logic [31:0] RDR_COUNT,
  input wire logic [15:0] RDR_CHAN,
  input wire logic [15:0] RDR_XID,
  input wire logic [31:0] RDR_OPATH,
  input wire logic [7:0] RDR_OPORT,
  input wire logic RDR_FINAL,
  output logic RDR_REFUSE
);
  typedef enum logic [2:0] {
    PS_IDLE, PS_HDR_HI, PS_HDR_LO, PS_PAY, PS_RDR
  } ssr_pstate_e;
  ssr_pstate_e state_reg, state_next;
  logic [4:0] rx_pos_reg, rdr_pos_reg;
  logic [103:0] rx_sh_reg;
  logic [167:0] rdr_sh_reg;
  logic job_busy_reg;
  logic [15:0] job_chan_reg;
  logic [31:0] job_rem_reg;
  logic [7:0] fr_cnt_reg;

  // decode of an incoming request at its last byte
  wire rx_fire = LNK.d2o_valid && LNK.d2o_ready;
  wire rx_end = rx_fire && LNK.d2o_last && !LNK.d2o_frame;
  wire [111:0] msg = {rx_sh_reg, LNK.d2o_data};
  wire [31:0] m_ofs = msg[ssr_pkg::RQ_OFS +: 32];
  wire [31:0] m_cnt = msg[ssr_pkg::RQ_CNT +: 32];
  wire [32:0] m_end = {1'b0, m_ofs} + {1'b0, m_cnt};
  wire m_final = m_end == {1'b0, IO_LEN};
  wire m_bad = msg[ssr_pkg::RQ_CODE +: 8] != ssr_pkg::CODE_DATA_REQ
    || rx_pos_reg != ssr_pkg::REQ_LAST_POS
    || (|m_ofs[2:0]) || ((|m_cnt[2:0]) && !m_final)
    || m_end > {1'b0, IO_LEN}; // see (R6)
  wire job_load = rx_end && !m_bad && (|m_cnt);
  // one request served at a time, so later ones wait on the link
  assign LNK.d2o_ready = !job_busy_reg;

  // redirect issue; refused if the count breaks the eight-byte rule
  wire rdr_fire = RDR_VALID && RDR_READY;
  wire rdr_bad = (|RDR_COUNT[2:0]) && !RDR_FINAL; // see (R16)
  assign RDR_READY = state_reg == PS_IDLE && !job_busy_reg;

  // outgoing stream selection
  wire in_pay = state_reg == PS_PAY;
  wire in_rdr = state_reg == PS_RDR;
  wire pay_last = job_rem_reg == 32'h1
    || fr_cnt_reg == ssr_pkg::FRAME_PAYLOAD - 8'h1; // see (R11)
  assign LNK.o2d_valid = in_pay ? SRC_VALID : (state_reg != PS_IDLE);
  assign LNK.o2d_data = in_rdr ? rdr_sh_reg[167:160] :
    in_pay ? SRC_DATA :
    state_reg == PS_HDR_HI ? job_chan_reg[15:8] : job_chan_reg[7:0];
  assign LNK.o2d_last = (in_pay && pay_last)
    || (in_rdr && rdr_pos_reg == ssr_pkg::RDR_LAST_POS);
  assign LNK.o2d_frame = !in_rdr;
  assign SRC_READY = in_pay && LNK.o2d_ready;
  wire tx_fire = LNK.o2d_valid && LNK.o2d_ready;

  // sequencer: frames for the open request first, then redirects
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PS_IDLE: begin
        if (job_busy_reg) begin
          state_next = PS_HDR_HI;
        end else if (rdr_fire && !rdr_bad) begin
          state_next = PS_RDR;
        end
      end
      PS_HDR_HI: if (tx_fire) state_next = PS_HDR_LO;
      PS_HDR_LO: if (tx_fire) state_next = PS_PAY;
      PS_PAY: if (tx_fire && pay_last) state_next = PS_IDLE;
      PS_RDR: if (tx_fire && LNK.o2d_last) state_next = PS_IDLE;
      default: state_next = PS_IDLE;
    endcase
  end

  // request receive and job bookkeeping
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_pos_reg <= 5'h00;
      rx_sh_reg <= '0;
      job_busy_reg <= 1'b0;
      job_chan_reg <= 16'h0000;
      job_rem_reg <= 32'h0;
      ABORT <= 1'b0;
      REQ_SEEN <= 1'b0;
      REQ_TAG <= 16'h0000;
      REQ_OFFSET <= 32'h0;
      REQ_COUNT <= 32'h0;
      REQ_CHAN <= 16'h0000;
    end else begin
      ABORT <= rx_end && m_bad; // see (R8)
      REQ_SEEN <= job_load;
      if (rx_fire) begin
        rx_sh_reg <= {rx_sh_reg[95:0], LNK.d2o_data};
        rx_pos_reg <= LNK.d2o_last ? 5'h00 :
          (rx_pos_reg == ssr_pkg::POS_MAX ? rx_pos_reg : rx_pos_reg + 5'h1);
      end
      if (job_load) begin
        job_busy_reg <= 1'b1;
        job_chan_reg <= msg[ssr_pkg::RQ_CHAN +: 16]; // see (R9)
        job_rem_reg <= m_cnt;
        REQ_TAG <= msg[ssr_pkg::RQ_TAG +: 16];
        REQ_OFFSET <= m_ofs;
        REQ_COUNT <= m_cnt;
        REQ_CHAN <= msg[ssr_pkg::RQ_CHAN +: 16];
      end else if (in_pay && tx_fire) begin
        job_rem_reg <= job_rem_reg - 32'h1;
        if (job_rem_reg == 32'h1) job_busy_reg <= 1'b0;
      end
    end
  end

  // transmit side registers
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= PS_IDLE;
      fr_cnt_reg <= 8'h00;
      rdr_pos_reg <= 5'h00;
      rdr_sh_reg <= '0;
      RDR_REFUSE <= 1'b0;
    end else begin
      state_reg <= state_next;
      RDR_REFUSE <= rdr_fire && rdr_bad;
      if (state_reg == PS_HDR_HI) fr_cnt_reg <= 8'h00;
      else if (in_pay && tx_fire) fr_cnt_reg <= fr_cnt_reg + 8'h01;
      if (rdr_fire && !rdr_bad) begin
        // tag and transfer id come straight from the offer
        rdr_sh_reg <= {ssr_pkg::CODE_REDIRECT, ssr_pkg::RSVD_BYTE,
          RDR_TAG, RDR_RPID, RDR_COUNT, RDR_CHAN, RDR_XID,
          RDR_OPATH, RDR_OPORT}; // see (R12) (R18) (R21) (R22)
        rdr_pos_reg <= 5'h00;
      end else if (in_rdr && tx_fire) begin
        rdr_sh_reg <= {rdr_sh_reg[159:0], ssr_pkg::RSVD_BYTE};
        rdr_pos_reg <= rdr_pos_reg + 5'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/ssr_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
// watches both directions of the link between the two ends
module ssr_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d2o_valid,
  input wire logic d2o_ready,
  input wire logic [7:0] d2o_data,
  input wire logic d2o_last,
  input wire logic d2o_frame,
  input wire logic o2d_valid,
  input wire logic o2d_ready,
  input wire logic [7:0] o2d_data,
  input wire logic o2d_last,
  input wire logic o2d_frame
);
  logic d_fire;
  logic o_fire;
  logic [4:0] dpos_reg;
  logic [4:0] dpos_next;
  logic [4:0] opos_reg;
  logic [4:0] opos_next;
  logic [15:0] chan_reg;
  logic [15:0] chan_next;
  logic hi_pos;
  logic lo_pos;
  // byte position inside the current unit, per direction
  assign d_fire = d2o_valid && d2o_ready;
  assign o_fire = o2d_valid && o2d_ready;
  assign dpos_next = !d_fire ? dpos_reg : d2o_last ? 5'h00 : dpos_reg + 5'h01;
  assign opos_next = !o_fire ? opos_reg : o2d_last ? 5'h00 : opos_reg + 5'h01;
  // channel of the last request; frames answering it must carry it
  assign hi_pos = d_fire && dpos_reg == 5'h0c;
  assign lo_pos = d_fire && dpos_reg == 5'h0d;
  assign chan_next = hi_pos ? {d2o_data, chan_reg[7:0]} :
                     lo_pos ? {chan_reg[15:8], d2o_data} : chan_reg;
  // helper state only; cleared with the link
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dpos_reg <= 5'h00;
      opos_reg <= 5'h00;
      chan_reg <= 16'h0000;
    end else begin
      dpos_reg <= dpos_next;
      opos_reg <= opos_next;
      chan_reg <= chan_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_req_code;
    d2o_valid && dpos_reg == 5'h00 |-> d2o_data == 8'h22 && !d2o_frame;
  endproperty
  a_req_code: assert property (p_req_code)
    else $error("bad code");
  property p_req_rsvd;
    d2o_valid && dpos_reg == 5'h01 |-> d2o_data == 8'h00;
  endproperty
  a_req_rsvd: assert property (p_req_rsvd)
    else $error("bad rsvd");
  property p_req_len; d_fire && d2o_last |-> dpos_reg == 5'h0d; endproperty
  a_req_len: assert property (p_req_len)
    else $error("bad length");
  property p_ofs_mod8;
    d_fire && dpos_reg == 5'h07 |-> d2o_data[2:0] == 3'h0;
  endproperty
  a_ofs_mod8: assert property (p_ofs_mod8)
    else $error("bad offset");
  // a stalled byte must not move until it is taken
  property p_d2o_hold;
    d2o_valid && !d2o_ready |=> d2o_valid && $stable(d2o_data)
      && $stable(d2o_last);
  endproperty
  a_d2o_hold: assert property (p_d2o_hold)
    else $error("byte moved");
  property p_frame_chan;
    o2d_valid && o2d_frame && opos_reg < 5'h02 |->
      o2d_data == (opos_reg == 5'h00 ? chan_reg[15:8] : chan_reg[7:0]);
  endproperty
  a_frame_chan: assert property (p_frame_chan)
    else $error("bad chan");
  property p_frame_len;
    o_fire && o2d_frame && o2d_last |-> opos_reg >= 5'h02 && opos_reg <= 5'h11;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("bad frame");
  // every message from the peer opens with the redirect code
  property p_rdr_code;
    o2d_valid && !o2d_frame && opos_reg == 5'h00 |-> o2d_data == 8'h23;
  endproperty
  a_rdr_code: assert property (p_rdr_code)
    else $error("bad rdr");
  property p_rdr_len;
    o_fire && !o2d_frame && o2d_last |-> opos_reg == 5'h14;
  endproperty
  a_rdr_len: assert property (p_rdr_len)
    else $error("rdr length");
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  logic ref_clk, resetn, req_valid, req_final, req_ready, req_reject;
  logic [31:0] req_offset, req_count, io_len, rem_len, cmd_rpid;
  logic [15:0] req_chan, cmd_tag, rx_chan, d_xid, p_tag, p_chan;
  logic [1:0] req_pending;
  logic rx_valid, d_rdr_valid, rdr_done, alert_valid, resp_valid;
  logic [7:0] rx_data, rdr_port, alert_code, resp_code, src_data, rx_exp;
  logic [47:0] rdr_addr;
  logic [31:0] d_count, p_ofs, p_cnt, r_rpid, r_cnt;
  logic abort, req_seen, src_valid, src_ready, r_valid, r_ready, r_fin;
  logic r_refuse;
  logic [15:0] r_tag, r_chan;
  int n_fail, checks, rx_n, evc[7];
  ssr_link_if lnk (.clk(ref_clk), .rst_n(resetn));
  ssr_dev i_ssr_dev (.REF_CLK(ref_clk), .RESETN(resetn), .LNK(lnk.dev),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_OFFSET(req_offset),
    .REQ_COUNT(req_count), .REQ_CHAN(req_chan), .REQ_FINAL(req_final),
    .IO_LEN(io_len), .REQ_REJECT(req_reject), .REQ_PENDING(req_pending),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_CHAN(rx_chan),
    .CMD_TAG(cmd_tag), .CMD_RPID(cmd_rpid), .REM_LEN(rem_len),
    .RDR_VALID(d_rdr_valid), .RDR_ADDR(rdr_addr), .RDR_PORT(rdr_port),
    .RDR_COUNT(d_count), .RDR_XID(d_xid), .RDR_DONE(rdr_done),
    .ALERT_VALID(alert_valid), .ALERT_CODE(alert_code),
    .RESP_VALID(resp_valid), .RESP_CODE(resp_code));
  ssr_peer i_ssr_peer (.REF_CLK(ref_clk), .RESETN(resetn), .LNK(lnk.peer),
    .IO_LEN(io_len), .ABORT(abort), .REQ_SEEN(req_seen), .REQ_TAG(p_tag),
    .REQ_OFFSET(p_ofs), .REQ_COUNT(p_cnt), .REQ_CHAN(p_chan),
    .SRC_VALID(src_valid), .SRC_READY(src_ready), .SRC_DATA(src_data),
    .RDR_VALID(r_valid), .RDR_READY(r_ready), .RDR_TAG(r_tag),
    .RDR_RPID(r_rpid), .RDR_COUNT(r_cnt), .RDR_CHAN(r_chan),
    .RDR_XID({8'h7e, r_chan[7:0]}), .RDR_OPATH(32'h0a0b0c0d),
    .RDR_OPORT(8'h03), .RDR_FINAL(r_fin), .RDR_REFUSE(r_refuse));
  ssr_asserts i_ssr_asserts (.clk(ref_clk), .rst_n(resetn),
    .d2o_valid(lnk.d2o_valid), .d2o_ready(lnk.d2o_ready),
    .d2o_data(lnk.d2o_data), .d2o_last(lnk.d2o_last),
    .d2o_frame(lnk.d2o_frame), .o2d_valid(lnk.o2d_valid),
    .o2d_ready(lnk.o2d_ready), .o2d_data(lnk.o2d_data),
    .o2d_last(lnk.o2d_last), .o2d_frame(lnk.o2d_frame));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // payload source advances only on a taken byte
  always @(posedge ref_clk) begin
    if (src_valid && src_ready === 1'b1) src_data <= src_data + 8'h01;
  end
  // counters of one-cycle pulses; t_req and rdr compare before and after
  always @(posedge ref_clk) begin
    if (req_reject === 1'b1) evc[0] <= evc[0] + 1;
    if (d_rdr_valid === 1'b1) evc[1] <= evc[1] + 1;
    if (alert_valid === 1'b1) evc[2] <= evc[2] + 1;
    if (resp_valid === 1'b1) evc[3] <= evc[3] + 1;
    if (r_refuse === 1'b1) evc[4] <= evc[4] + 1;
    if (req_seen === 1'b1) evc[5] <= evc[5] + 1;
    if (abort === 1'b1) evc[6] <= evc[6] + 1;
    if (rx_valid === 1'b1) begin
      `CHK(rx_data, rx_exp)
      `CHK(rx_chan, 16'h0005)
      rx_exp <= rx_exp + 8'h01;
      rx_n <= rx_n + 1;
    end
  end
  task automatic end_sim;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // request held until taken, then dropped at that same edge
  task automatic do_req(input [31:0] o, c, input logic f);
    @(posedge ref_clk);
    req_offset <= o;
    req_count <= c;
    req_final <= f;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 300 && req_ready !== 1'b1; i++) @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask
  task automatic t_req;
    int b;
    b = evc[5];
    do_req(32'h0, 32'h10, 1'b0);
    @(negedge ref_clk);
    `CHK(req_ready, 1'b0)
    repeat (40) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(evc[5] - b, 1)
    `CHK({p_tag, p_chan}, {16'h1234, 16'h5})
    `CHK({p_ofs, p_cnt}, {32'h0, 32'h10})
    do_req(32'h10, 32'h10, 1'b1);
    `CHK(rx_n, 16)
    repeat (60) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK({req_pending, rx_n}, {2'h0, 32'd32})
    $display("request test done");
  endtask
  task automatic t_rej;
    logic [31:0] o[4] = '{32'h4, 32'h0, 32'h10, 32'h0};
    logic [31:0] c[4] = '{32'h10, 32'hc, 32'h18, 32'h0};
    for (int i = 0; i < 4; i++) begin
      do_req(o[i], c[i], 1'b0);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(evc[0], i + 1)
    end
    $display("reject test done");
  endtask
  // one redirect through the peer; k picks the pulse that must follow
  task automatic rdr(input logic [15:0] tg, input logic [31:0] rp, cn,
                     input logic [15:0] ch, input logic fin, input int k,
                     input logic [7:0] code);
    int b[7];
    @(posedge ref_clk);
    b = evc;
    r_tag <= tg;
    r_rpid <= rp;
    r_cnt <= cn;
    r_chan <= ch;
    r_fin <= fin;
    r_valid <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 100 && r_ready !== 1'b1; i++) @(posedge ref_clk);
    r_valid <= 1'b0;
    repeat (40) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(evc[k] - b[k], 1)
    `CHK(evc[1] - b[1], int'(k == 1))
    if (k == 2) `CHK(alert_code, code)
    if (k == 3) `CHK(resp_code, code)
    if (k == 1) begin
      `CHK({rdr_addr, rdr_port}, {32'h0a0b0c0d, ch, 8'h03})
      `CHK({d_count, d_xid}, {cn, 8'h7e, ch[7:0]})
    end
  endtask
  task automatic pulse_done;
    @(posedge ref_clk);
    rdr_done <= 1'b1;
    @(posedge ref_clk);
    rdr_done <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic t_rdr;
    rdr(16'h1234, 32'h00c0ffee, 32'h10, 16'h7, 1'b0, 1, 8'h00);
    rdr(16'h1234, 32'h00c0ffef, 32'h10, 16'h8, 1'b0, 2,
        ssr_pkg::ALERT_BAD_RPATH);
    rdr(16'h1234, 32'h00c0ffee, 32'hc, 16'h8, 1'b1, 2,
        ssr_pkg::ALERT_BAD_FIELD);
    rdr(16'h1234, 32'h00c0ffee, 32'hc, 16'h8, 1'b0, 4, 8'h00);
    rdr(16'h4321, 32'h00c0ffee, 32'h10, 16'h8, 1'b0, 3,
        ssr_pkg::RESP_BAD_FIELD);
    rdr(16'h1234, 32'h00c0ffee, 32'h10, 16'h8, 1'b0, 1, 8'h00);
    rdr(16'h1234, 32'h00c0ffee, 32'h10, 16'h9, 1'b0, 2,
        ssr_pkg::ALERT_TOO_MANY);
    pulse_done();
    pulse_done();
    rdr(16'h1234, 32'h00c0ffee, 32'h10, 16'h9, 1'b0, 1, 8'h00);
    // same channel as the open one: held and link stalled until done
    fork
      rdr(16'h1234, 32'h00c0ffee, 32'h10, 16'h9, 1'b0, 1, 8'h00);
      begin
        repeat (30) @(posedge ref_clk);
        `CHK(evc[1], 3)
        `CHK(lnk.o2d_ready, 1'b0)
        pulse_done();
      end
    join
    $display("redirect test done");
  endtask
  // cut a hang short well past the expected run length
  initial begin
    #(50 * 6000);
    n_fail++;
    end_sim();
  end
  initial begin
    {resetn, req_valid, req_final, rdr_done, r_valid, r_fin} = '0;
    {req_offset, req_count, r_rpid, r_cnt} = '0;
    evc = '{default: 0};
    {src_valid, rx_n, r_tag, r_chan} = '0;
    req_chan = 16'h0005;
    io_len = 32'h20;
    rem_len = 32'h40;
    cmd_tag = 16'h1234;
    cmd_rpid = 32'h00c0ffee;
    src_data = 8'h40;
    rx_exp = 8'h40;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    src_valid <= 1'b1;
    @(posedge ref_clk);
    t_rej();
    t_req();
    t_rdr();
    `CHK(evc[6], 0)
    end_sim();
  end
endmodule
`default_nettype wire
